// ==== src/ctr_pkg.sv ====
package ctr_pkg;

	// ****************************************
	// Array dimensions
	// ****************************************
	// Timers in the array
	localparam int NTMR = 16;
	// Pads that can feed or receive timer signals
	localparam int NPAD = 32;
	// Register address width in bits
	localparam int ADDR_W = 12;

	// ****************************************
	// Register map
	// ****************************************
	// Per-timer block offsets, stride of one block
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_CNT = 5'h04;
	localparam logic [4:0] OFS_CMP0 = 5'h08;
	localparam logic [4:0] OFS_CMP1 = 5'h0c;
	localparam logic [4:0] OFS_REP = 5'h10;
	// Global registers
	localparam logic [11:0] ADR_TMR_END = 12'h200;
	localparam logic [11:0] ADR_STAT = 12'h200;
	localparam logic [11:0] ADR_MASK = 12'h204;
	localparam logic [11:0] ADR_PAD = 12'h300;
	localparam logic [11:0] ADR_PAD_END = 12'h380;

	// ****************************************
	// Control word fields
	// ****************************************
	localparam int CT_EN = 0;
	localparam int CT_MODE = 1;
	localparam int CT_INIT = 4;
	localparam int CT_STOP = 5;
	localparam int CT_INV0 = 6;
	localparam int CT_INV1 = 7;
	localparam int CT_CLK = 8;
	localparam int CT_TRIG_EN = 15;
	localparam int CT_TRIG = 16;
	localparam int CT_LMT = 24;
	// Pad route word: enable bit and source index
	localparam int PR_EN = 5;

	// ****************************************
	// Clock source selector codes
	// ****************************************
	localparam logic [6:0] CLK_TAP_END = 7'h04;
	localparam logic [6:0] CLK_TMR_BASE = 7'h08;
	localparam logic [6:0] CLK_PAD_BASE = 7'h20;
	// Prescaler width; taps at /2 /8 /32 /256
	localparam int PRE_W = 8;

	// ****************************************
	// Reset values and constants
	// ****************************************
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CMP_RST = 32'h0000_0000;
	localparam logic [7:0] LMT_BIG = 8'h1f;
	localparam logic [4:0] SEQ_LAST = 5'h1f;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;

	// Operating modes
	typedef enum logic [2:0] {
		edge_count_mode = 3'b000,
		free_increment_mode = 3'b001,
		pulse_width_mode = 3'b010,
		one_shot_sequence_mode = 3'b011,
		looping_sequence_mode = 3'b100
	} ctr_mode_t;

endpackage

// ==== src/ctr_sync.sv ====
`timescale 1ns/1ps
module ctr_sync #(
	parameter int W = 1
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] level_o,
	output logic [W-1:0] rise_o,
	output logic [W-1:0] change_o
);
	import ctr_pkg::*;

	// ****************************************
	// Three-stage input filter
	// ****************************************
	typedef struct packed {
		logic [W-1:0] q1;
		logic [W-1:0] q2;
		logic [W-1:0] q3;
		logic [W-1:0] lvl;
		logic [W-1:0] rise;
		logic [W-1:0] chg;
	} ctr_sync_t;

	ctr_sync_t s;
	ctr_sync_t next_s;
	// Bits where stages two and three agree
	logic [W-1:0] agree;

	// Accept a new level only when the later stages agree
	always_comb begin
		next_s = s;
		next_s.q1 = async_i;
		next_s.q2 = s.q1;
		next_s.q3 = s.q2;
		agree = ~(s.q2 ^ s.q3);
		next_s.lvl = (agree & s.q3) | (~agree & s.lvl);
		next_s.rise = ~s.lvl & next_s.lvl;
		next_s.chg = s.lvl ^ next_s.lvl;
	end

	// State register
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level_o = s.lvl;
	assign rise_o = s.rise;
	assign change_o = s.chg;

endmodule

// ==== src/ctr_timer.sv ====
`timescale 1ns/1ps
module ctr_timer (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic en_i,
	input wire ctr_pkg::ctr_mode_t mode_i,
	input wire logic stop_i,
	input wire logic inv0_i,
	input wire logic inv1_i,
	input wire logic trig_en_i,
	input wire logic trig_i,
	input wire logic tick_i,
	input wire logic init_i,
	input wire logic cnt_wr_i,
	input wire logic [31:0] cnt_wdata_i,
	input wire logic [31:0] cmp0_i,
	input wire logic [31:0] cmp1_i,
	input wire logic [7:0] lmt_i,
	output logic [31:0] cnt_o,
	output logic [7:0] rep_o,
	output logic w0_o,
	output logic w1_o,
	output logic ev0_o,
	output logic ev1_o
);
	import ctr_pkg::*;

	// ****************************************
	// One counter channel
	// ****************************************
	typedef struct packed {
		logic [31:0] cnt;
		logic [7:0] rep;
		logic run;
		logic done;
		logic big;
		logic w0;
		logic w1;
		logic ev0;
		logic ev1;
	} ctr_tmr_t;

	ctr_tmr_t s;
	ctr_tmr_t next_s;
	// Sequence playback selected
	logic seq;
	// Pulse-width mode selected
	logic pwm;

	// Counting, matching and playback
	always_comb begin
		next_s = s;
		next_s.ev0 = 1'b0;
		next_s.ev1 = 1'b0;
		seq = (mode_i == one_shot_sequence_mode) ||
			(mode_i == looping_sequence_mode);
		pwm = (mode_i == pulse_width_mode);
		if (init_i) begin
			next_s.cnt = '0;
			next_s.rep = '0;
			next_s.run = 1'b0;
			next_s.done = 1'b0;
			next_s.w0 = seq & cmp0_i[0];
			next_s.w1 = seq & cmp1_i[0];
		end else if (cnt_wr_i) begin
			next_s.cnt = cnt_wdata_i;
		end else if (!en_i) begin
			// Disabled: halt and rearm
			next_s.run = 1'b0;
			next_s.done = 1'b0;
		end else if (!s.run) begin
			if (!s.done && (!trig_en_i || trig_i)) begin
				next_s.run = 1'b1;
				next_s.big = (lmt_i == LMT_BIG);
			end
		end else if (tick_i && seq) begin
			// Pattern bit per tick, 32 ticks per repeat
			next_s.w0 = cmp0_i[s.cnt[4:0]];
			next_s.w1 = cmp1_i[s.cnt[4:0]];
			if (s.cnt[4:0] == SEQ_LAST) begin
				next_s.cnt = '0;
				next_s.rep = s.rep + 8'h01;
				if (lmt_i != 8'h00 && next_s.rep == lmt_i) begin
					next_s.ev0 = 1'b1;
					next_s.ev1 = s.big;
					if (mode_i == one_shot_sequence_mode) begin
						next_s.run = 1'b0;
						next_s.done = 1'b1;
					end else begin
						next_s.rep = '0;
					end
				end
			end else begin
				next_s.cnt = s.cnt + 32'h1;
			end
		end else if (tick_i) begin
			if (s.cnt == cmp1_i) begin
				next_s.ev1 = 1'b1;
				next_s.w0 = pwm | ~s.w0;
				next_s.w1 = pwm | ~s.w1;
			end
			if (s.cnt == cmp0_i) begin
				next_s.ev0 = 1'b1;
				next_s.cnt = '0;
				next_s.run = ~stop_i;
				next_s.done = stop_i;
				next_s.w0 = ~pwm & ~s.w0;
				next_s.w1 = pwm ? 1'b0 : next_s.w1;
			end else begin
				next_s.cnt = s.cnt + 32'h1;
			end
		end
	end

	// State register
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign cnt_o = s.cnt;
	assign rep_o = s.rep;
	assign w0_o = s.w0 ^ inv0_i;
	assign w1_o = s.w1 ^ inv1_i;
	assign ev0_o = s.ev0;
	assign ev1_o = s.ev1;

endmodule

// ==== src/ctr_top.sv ====
`timescale 1ns/1ps
module ctr_top (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [ctr_pkg::NPAD-1:0] gpio_i,
	output logic [ctr_pkg::NPAD-1:0] pad_o,
	output logic [ctr_pkg::NPAD-1:0] pad_en_o,
	output logic irq_o
);
	import ctr_pkg::*;

	// ****************************************
	// State of the whole array
	// ****************************************
	typedef struct packed {
		logic [NTMR-1:0][31:0] ctrl;
		logic [NTMR-1:0][31:0] cmp0;
		logic [NTMR-1:0][31:0] cmp1;
		logic [NPAD-1:0][5:0] route;
		logic [NTMR-1:0] prev_w;
		logic [PRE_W-1:0] pre;
		logic [2*NTMR-1:0] stat;
		logic [2*NTMR-1:0] mask;
		logic irq;
		logic [NPAD-1:0] pad;
		logic [NPAD-1:0] pad_en;
		logic awready;
		logic wready;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ctr_top_t;

	ctr_top_t s;
	ctr_top_t next_s;

	// Synchronised pad inputs
	logic [NPAD-1:0] pad_lvl;
	logic [NPAD-1:0] pad_rise;
	logic [NPAD-1:0] pad_chg;
	// Per-timer wires
	logic [NTMR-1:0] tick;
	logic [NTMR-1:0] trig;
	logic [NTMR-1:0] init;
	logic [NTMR-1:0] cnt_wr;
	logic [NTMR-1:0][31:0] cnt;
	logic [NTMR-1:0][7:0] rep;
	logic [NTMR-1:0] w0;
	logic [NTMR-1:0] w1;
	logic [NTMR-1:0] ev0;
	logic [NTMR-1:0] ev1;
	// Generator taps, one-cycle pulses
	logic [3:0] tap;
	// Write commits this cycle
	logic wr_go;
	// Read taken this cycle
	logic rd_go;
	// Decode helpers
	logic [3:0] w_tmr;
	logic [4:0] w_ofs;
	logic w_in_tmr;

	// ****************************************
	// Helpers
	// ****************************************
	// Byte-lane merge for partial writes
	function automatic logic [31:0] ctr_merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = data[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Pad inputs cross into the bus clock
	ctr_sync #(.W(NPAD)) u_sync (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.async_i(gpio_i),
		.level_o(pad_lvl),
		.rise_o(pad_rise),
		.change_o(pad_chg)
	);

	assign tap[0] = s.pre[0];
	assign tap[1] = &s.pre[2:0];
	assign tap[2] = &s.pre[4:0];
	assign tap[3] = &s.pre[7:0];

	assign wr_go = !s.awready && !s.wready && !s.bvalid;
	assign rd_go = s_axi_arvalid_i && s.arready;
	assign w_tmr = s.awaddr[8:5];
	assign w_ofs = s.awaddr[4:0];
	assign w_in_tmr = (s.awaddr < ADR_TMR_END);

	// ****************************************
	// Timer channels
	// ****************************************
	// sixteen independent channels
	for (genvar t = 0; t < NTMR; t++) begin : g_tmr
		// Source select, edges of chosen clock
		logic [6:0] sel;
		logic [6:0] pidx;
		logic [3:0] tidx;
		logic src_rise;
		logic src_chg;

		always_comb begin
			sel = s.ctrl[t][CT_CLK +: 7];
			pidx = sel - CLK_PAD_BASE;
			tidx = 4'(sel - CLK_TMR_BASE);
			src_rise = 1'b0;
			src_chg = 1'b0;
			if (sel < CLK_TAP_END) begin
				src_rise = tap[sel[1:0]];
				src_chg = tap[sel[1:0]];
			end else if (sel >= CLK_TMR_BASE && sel < CLK_PAD_BASE &&
				tidx != 4'(t)) begin
				src_rise = w0[tidx] & ~s.prev_w[tidx];
				src_chg = w0[tidx] ^ s.prev_w[tidx];
			end else if (sel >= CLK_PAD_BASE) begin
				src_rise = pad_rise[pidx[4:0]];
				src_chg = pad_chg[pidx[4:0]];
			end
		end

		assign tick[t] = (s.ctrl[t][CT_MODE +: 3] ==
			edge_count_mode) ? src_chg : src_rise;
		assign trig[t] = pad_rise[s.ctrl[t][CT_TRIG +: 5]];
		// init pulse from the control write
		assign init[t] = wr_go && w_in_tmr && w_tmr == 4'(t) &&
			w_ofs == OFS_CTRL && s.wstrb[0] && s.wdata[CT_INIT];
		assign cnt_wr[t] = wr_go && w_in_tmr && w_tmr == 4'(t) &&
			w_ofs == OFS_CNT;

		ctr_timer u_tmr (
			.mclk_i(mclk_i),
			.rstn_i(rstn_i),
			.en_i(s.ctrl[t][CT_EN]),
			.mode_i(ctr_mode_t'(s.ctrl[t][CT_MODE +: 3])),
			.stop_i(s.ctrl[t][CT_STOP]),
			.inv0_i(s.ctrl[t][CT_INV0]),
			.inv1_i(s.ctrl[t][CT_INV1]),
			.trig_en_i(s.ctrl[t][CT_TRIG_EN]),
			.trig_i(trig[t]),
			.tick_i(tick[t]),
			.init_i(init[t]),
			.cnt_wr_i(cnt_wr[t]),
			.cnt_wdata_i(ctr_merge(cnt[t], s.wdata, s.wstrb)),
			.cmp0_i(s.cmp0[t]),
			.cmp1_i(s.cmp1[t]),
			.lmt_i(s.ctrl[t][CT_LMT +: 8]),
			.cnt_o(cnt[t]),
			.rep_o(rep[t]),
			.w0_o(w0[t]),
			.w1_o(w1[t]),
			.ev0_o(ev0[t]),
			.ev1_o(ev1[t])
		);
	end

	// ****************************************
	// Bus slave, registers, interrupts, pads
	// ****************************************
	always_comb begin
		logic [3:0] r_tmr;
		logic [4:0] r_ofs;
		logic [31:0] wv;
		logic [5:0] src;
		r_tmr = s_axi_araddr_i[8:5];
		r_ofs = s_axi_araddr_i[4:0];
		wv = '0;
		src = '0;
		next_s = s;
		next_s.pre = s.pre + 8'h01;
		next_s.prev_w = w0;

		// Write address and data taken in either order
		if (s_axi_awvalid_i && s.awready) begin
			next_s.awready = 1'b0;
			next_s.awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s.wready) begin
			next_s.wready = 1'b0;
			next_s.wdata = s_axi_wdata_i;
			next_s.wstrb = s_axi_wstrb_i;
		end

		// Commit once both halves are held
		if (wr_go) begin
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OK;
			if (w_in_tmr) begin
				if (w_ofs == OFS_CTRL) begin
					wv = ctr_merge(s.ctrl[w_tmr], s.wdata, s.wstrb);
					// Init bit is a strobe, never stored
					wv[CT_INIT] = 1'b0;
					next_s.ctrl[w_tmr] = wv;
				end else if (w_ofs == OFS_CMP0) begin
					next_s.cmp0[w_tmr] =
						ctr_merge(s.cmp0[w_tmr], s.wdata, s.wstrb);
				end else if (w_ofs == OFS_CMP1) begin
					next_s.cmp1[w_tmr] =
						ctr_merge(s.cmp1[w_tmr], s.wdata, s.wstrb);
				end else if (w_ofs != OFS_CNT) begin
					next_s.bresp = RESP_ERR;
				end
			end else if (s.awaddr == ADR_MASK) begin
				next_s.mask = ctr_merge(s.mask, s.wdata, s.wstrb);
			end else if (s.awaddr >= ADR_PAD && s.awaddr < ADR_PAD_END &&
				s.awaddr[1:0] == 2'b00) begin
				wv = ctr_merge(32'(s.route[s.awaddr[6:2]]), s.wdata,
					s.wstrb);
				next_s.route[s.awaddr[6:2]] = wv[5:0];
			end else if (s.awaddr != ADR_STAT) begin
				// Unmapped: refuse, nothing stored
				next_s.bresp = RESP_ERR;
			end
		end
		if (s.bvalid && s_axi_bready_i) begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end

		// Read: data one cycle after the address
		if (rd_go) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OK;
			next_s.rdata = '0;
			if (s_axi_araddr_i < ADR_TMR_END) begin
				if (r_ofs == OFS_CTRL) begin
					next_s.rdata = s.ctrl[r_tmr];
				end else if (r_ofs == OFS_CNT) begin
					next_s.rdata = cnt[r_tmr];
				end else if (r_ofs == OFS_CMP0) begin
					next_s.rdata = s.cmp0[r_tmr];
				end else if (r_ofs == OFS_CMP1) begin
					next_s.rdata = s.cmp1[r_tmr];
				end else if (r_ofs == OFS_REP) begin
					next_s.rdata = 32'(rep[r_tmr]);
				end else begin
					next_s.rresp = RESP_ERR;
				end
			end else if (s_axi_araddr_i == ADR_STAT) begin
				next_s.rdata = s.stat;
				// Reading the status clears it
				next_s.stat = '0;
			end else if (s_axi_araddr_i == ADR_MASK) begin
				next_s.rdata = s.mask;
			end else if (s_axi_araddr_i >= ADR_PAD &&
				s_axi_araddr_i < ADR_PAD_END &&
				s_axi_araddr_i[1:0] == 2'b00) begin
				next_s.rdata = 32'(s.route[s_axi_araddr_i[6:2]]);
			end else begin
				next_s.rresp = RESP_ERR;
			end
		end
		if (s.rvalid && s_axi_rready_i) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end

		// two flags per timer, set beats clear
		for (int t = 0; t < NTMR; t++) begin
			if (ev0[t]) begin
				next_s.stat[2*t] = 1'b1;
			end
			if (ev1[t]) begin
				next_s.stat[2*t+1] = 1'b1;
			end
		end
		next_s.irq = |(next_s.stat & s.mask);

		for (int p = 0; p < NPAD; p++) begin
			src = s.route[p];
			next_s.pad_en[p] = src[PR_EN];
			next_s.pad[p] = src[0] ? w1[src[4:1]] : w0[src[4:1]];
		end
	end

	// State register
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.ctrl <= {NTMR{CTRL_RST}};
			s.cmp0 <= {NTMR{CMP_RST}};
			s.cmp1 <= {NTMR{CMP_RST}};
		end else begin
			s <= next_s;
		end
	end

	// All outputs straight from flops
	assign s_axi_awready_o = s.awready;
	assign s_axi_wready_o = s.wready;
	assign s_axi_bresp_o = s.bresp;
	assign s_axi_bvalid_o = s.bvalid;
	assign s_axi_arready_o = s.arready;
	assign s_axi_rdata_o = s.rdata;
	assign s_axi_rresp_o = s.rresp;
	assign s_axi_rvalid_o = s.rvalid;
	assign pad_o = s.pad;
	assign pad_en_o = s.pad_en;
	assign irq_o = s.irq;

endmodule

// ==== tb/ctr_top_checker.sv ====
`timescale 1ns/1ps
module ctr_top_checker (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic irq_o
);
	import ctr_pkg::*;
	// ****************************************
	// Handshake helpers
	// ****************************************
	wire aw_hs = s_axi_awvalid_i && s_axi_awready_o; // Address taken
	wire w_hs = s_axi_wvalid_i && s_axi_wready_o; // Data taken
	wire ar_hs = s_axi_arvalid_i && s_axi_arready_o; // Read taken
	logic [2:0] ago; // Cycles since last access, saturating
	// Saturate so a long idle never wraps back into range
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ago <= 3'h7;
		end else if (ar_hs || aw_hs) begin
			ago <= 3'h0;
		end else if (ago != 3'h7) begin
			ago <= ago + 3'h1;
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	// ****************************************
	// Bus and interrupt checks
	// ****************************************
	sequence s_both;
		aw_hs && w_hs;
	endsequence
	sequence s_err_wr;
		aw_hs && w_hs && s_axi_awaddr_i == 12'h010;
	endsequence
	chk_write_answer: assert property (s_both |-> ##2 s_axi_bvalid_o)
		else $error("write answer not two cycles after handshake");
	chk_ready_block: assert property (s_axi_bvalid_o |->
		!s_axi_awready_o && !s_axi_wready_o)
		else $error("write channels ready while answer pending");
	chk_ready_back: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
		!s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o)
		else $error("write channels not reopened");
	chk_read_answer: assert property (ar_hs |=>
		s_axi_rvalid_o && !s_axi_arready_o)
		else $error("read answer late");
	chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
		else $error("read data moved before taken");
	chk_read_err: assert property (ar_hs && s_axi_araddr_i == 12'h208 |=>
		s_axi_rresp_o == RESP_ERR && s_axi_rdata_o == 32'h0)
		else $error("hole read not refused");
	chk_write_err: assert property (s_err_wr |-> ##2
		s_axi_bvalid_o && s_axi_bresp_o == RESP_ERR)
		else $error("read-only write not refused");
	chk_read_ok: assert property (ar_hs && s_axi_araddr_i == ADR_MASK |=>
		s_axi_rresp_o == RESP_OK)
		else $error("mask read refused");
	chk_irq_sticky: assert property ($fell(irq_o) |-> ago <= 3'h4)
		else $error("interrupt dropped without access");
	cover property (s_both);
endmodule

bind ctr_top ctr_top_checker i_chk (.mclk_i, .rstn_i, .s_axi_awaddr_i,
	.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
	.s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
	.s_axi_rvalid_o, .s_axi_rready_i, .irq_o);

// ==== tb/ctr_pad_model.sv ====
`timescale 1ns/1ps
module ctr_pad_model (
	input wire logic mclk_i,
	input wire logic [ctr_pkg::NPAD-1:0] pad_i,
	input wire logic [ctr_pkg::NPAD-1:0] pad_en_i,
	output logic [ctr_pkg::NPAD-1:0] gpio_o,
	output logic [ctr_pkg::NPAD-1:0] line_o
);
	import ctr_pkg::*;
	logic [NPAD-1:0] last = '0; // Previous wire level
	// Undriven pads flip every cycle, so a stale value never matches
	assign line_o = (pad_en_i & pad_i) | (~pad_en_i & ~last);
	always @(posedge mclk_i) begin
		last <= line_o;
	end
	initial gpio_o = '0;
	task automatic pulse(input int p, input int n);
		repeat (n) begin
			repeat (4) @(posedge mclk_i);
			gpio_o[p] <= 1'h1;
			repeat (4) @(posedge mclk_i);
			gpio_o[p] <= 1'h0;
		end
	endtask
	task automatic level(input int p, input logic v);
		@(posedge mclk_i);
		gpio_o[p] <= v;
	endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import ctr_pkg::*;
	logic mclk_i = 1'h0;
	logic rstn_i = 1'h0; // Active low
	logic [11:0] awaddr = '0, araddr = '0;
	logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
	logic [31:0] wdata = '0, d;
	logic [1:0] r;
	wire awready, wready, bvalid, arready, rvalid, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [NPAD-1:0] gpio, pad, pad_en, line;
	int failures = 0, checks_done = 0, cycles = 0;
	localparam logic [6:0] P5 = CLK_PAD_BASE + 7'h05; // Pad 5 clock
	ctr_top i_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .gpio_i(gpio), .pad_o(pad),
		.pad_en_o(pad_en), .irq_o(irq));
	ctr_pad_model i_pads (.mclk_i(mclk_i), .pad_i(pad), .pad_en_i(pad_en),
		.gpio_o(gpio), .line_o(line));
	always #20 mclk_i = ~mclk_i;
	// Hang guard
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("Counts: %0d checks, %0d failures", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// ****************************************
	// Bus tasks
	// ****************************************
	// Address and data offered together, each dropped when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] v,
		input logic [1:0] er = RESP_OK);
		logic aw_ok, w_ok;
		aw_ok = 1'h0;
		w_ok = 1'h0;
		@(posedge mclk_i);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge mclk_i);
			if (awvalid && awready) begin
				aw_ok = 1'h1;
				awvalid <= 1'h0;
			end
			if (wvalid && wready) begin
				w_ok = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge mclk_i); while (!bvalid);
		bready <= 1'h0;
		check({30'h0, bresp}, {30'h0, er});
	endtask
	// Ready raised late so the slave has to hold its answer
	task automatic rd(input logic [11:0] a);
		@(posedge mclk_i);
		araddr <= a;
		arvalid <= 1'h1;
		do @(posedge mclk_i); while (!arready);
		arvalid <= 1'h0;
		@(posedge mclk_i);
		rready <= 1'h1;
		do @(posedge mclk_i); while (!rvalid);
		rready <= 1'h0;
		d = rdata;
		r = rresp;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er = RESP_OK);
		rd(a);
		check(d, e);
		check({30'h0, r}, {30'h0, er});
	endtask
	function automatic logic [31:0] ctl(input ctr_mode_t m,
		input logic [6:0] c, input logic [7:0] l, input logic [2:0] f,
		input logic [4:0] tp);
		logic [31:0] v;
		v = CTRL_RST;
		v[CT_EN] = 1'h1;
		v[CT_MODE+:3] = m;
		v[CT_INIT] = 1'h1;
		v[CT_STOP] = f[0];
		v[CT_INV0] = f[1];
		v[CT_TRIG_EN] = f[2];
		v[CT_CLK+:7] = c;
		v[CT_TRIG+:5] = tp;
		v[CT_LMT+:8] = l;
		return v;
	endfunction
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (12) @(posedge mclk_i);
		rstn_i <= 1'h1;
		rc(12'h000, CTRL_RST);
		rc(ADR_MASK, 32'h0);
		rc(12'h014, 32'h0, RESP_ERR);
		rc(12'h208, 32'h0, RESP_ERR);
		wr(12'h010, 32'h5, RESP_ERR);
		rc(12'h010, 32'h0);
		wr(12'h004, 32'h1234_5678);
		rc(12'h004, 32'h1234_5678);
		$display("Test done: registers");
		// Compares set only while stopped
		wr(12'h008, 32'h14);
		wr(12'h00c, 32'h8);
		wr(12'h000, ctl(free_increment_mode, 7'h00, 8'h0, 3'h1, 5'h0));
		repeat (100) @(posedge mclk_i);
		check({31'h0, irq}, 32'h0);
		wr(ADR_MASK, 32'h3);
		repeat (3) @(posedge mclk_i);
		check({31'h0, irq}, 32'h1);
		rc(ADR_STAT, 32'h3);
		repeat (3) @(posedge mclk_i);
		check({31'h0, irq}, 32'h0);
		rc(12'h004, 32'h0);
		repeat (60) @(posedge mclk_i);
		rc(ADR_STAT, 32'h0);
		$display("Test done: free count");
		wr(ADR_PAD, 32'h22);
		wr(ADR_PAD + 12'h004, 32'h23);
		wr(12'h028, 32'h6);
		wr(12'h02c, 32'h3);
		wr(12'h020, ctl(pulse_width_mode, P5, 8'h0, 3'h2, 5'h0));
		repeat (8) @(posedge mclk_i);
		check({30'h0, line[1:0]}, 32'h1);
		i_pads.pulse(5, 4);
		repeat (8) @(posedge mclk_i);
		check({30'h0, line[1:0]}, 32'h2);
		check({31'h0, irq}, 32'h0);
		rc(ADR_STAT, 32'h8);
		i_pads.pulse(5, 3);
		repeat (8) @(posedge mclk_i);
		check({30'h0, line[1:0]}, 32'h1);
		rc(ADR_STAT, 32'h4);
		rc(12'h024, 32'h0);
		wr(12'h020, 32'h0);
		$display("Test done: pulse width");
		wr(12'h068, 32'h64);
		wr(12'h06c, 32'h32);
		wr(12'h060, ctl(edge_count_mode, P5, 8'h0, 3'h4, 5'h6));
		i_pads.pulse(5, 2);
		repeat (8) @(posedge mclk_i);
		rc(12'h064, 32'h0);
		i_pads.level(6, 1'h1);
		repeat (8) @(posedge mclk_i);
		i_pads.pulse(5, 2);
		repeat (8) @(posedge mclk_i);
		rc(12'h064, 32'h4);
		wr(12'h060, 32'h0);
		rd(ADR_STAT);
		$display("Test done: trigger");
		wr(12'h088, 32'h0f0f_00ff);
		wr(12'h08c, 32'h00ff_0f0f);
		wr(12'h080, ctl(one_shot_sequence_mode, P5, 8'h2, 3'h0, 5'h0));
		i_pads.pulse(5, 32);
		repeat (8) @(posedge mclk_i);
		rc(12'h090, 32'h1);
		i_pads.pulse(5, 32);
		repeat (8) @(posedge mclk_i);
		rc(ADR_STAT, 32'h100);
		wr(12'h080, ctl(looping_sequence_mode, P5, LMT_BIG, 3'h0, 5'h0));
		i_pads.pulse(5, 992);
		repeat (8) @(posedge mclk_i);
		rc(ADR_STAT, 32'h300);
		$display("Test done: sequences");
		wr(12'h0ec, 32'hffff_ffff);
		wr(12'h0c8, 32'hffff_ffff);
		wr(12'h0c0, ctl(free_increment_mode, CLK_TMR_BASE + 7'h07, 8'h0,
			3'h0, 5'h0));
		wr(12'h0e0, ctl(free_increment_mode, P5, 8'h0, 3'h0, 5'h0));
		i_pads.pulse(5, 4);
		repeat (8) @(posedge mclk_i);
		rc(12'h0c4, 32'h2);
		$display("Test done: chaining");
		stop_test();
	end
endmodule
